// ===== line_monitor.sv
// Observer on the four pattern lines
`timescale 1ns/1ps
module line_monitor (
  input wire logic clk,
  input wire logic clr,
  input wire logic [3:0] lines,
  output logic [15:0] highs [4],
  output logic [15:0] rises
);
  logic prev_zero;
  // Count high samples per line and rises on line zero
  always_ff @(posedge clk) begin
    prev_zero <= lines[0];
    for (int i = 0; i < 4; i++) highs[i] <= clr ? 16'h0 : highs[i] + 16'(lines[i]);
    rises <= clr ? 16'h0 : rises + 16'(lines[0] && !prev_zero);
  end
endmodule

// ===== pattern_gen.sv
// Four-line pattern generator with square, counter, arbitrary, manual, bus and PWM modes
// What this block does
// - Lines driven only while pattern output enabled
// - Square wave appears on line zero only
// - Counter shows 4-bit count, direction selectable
// - Count steps at f, lines toggle f/2..f/16
// - Manual mode holds each line static
// - Square period and frequency stay reciprocal
// - Square wave polarity normal or inverted
// - Square duty cycle programmable 1% to 99%
// - Arbitrary mode plays writable 4-bit samples
// - Every sample held for same bit time
// - Pattern period is length times bit time
// - Clear erases samples, length one, value zero
// - Burst pauses idle time after every NCYCLE patterns
// - Idle time 20 ns to 42 s, 10 ns steps
// - Pattern repeated programmed count per burst
// - Continuous trigger or single shot on trigger
// - Bus signals mapped to fixed lines, rest idle
// - Bus traffic pseudo-random, set by type, rate and UART polarity
// - Listed bus rates selectable, UART polarity selectable
// - Motor PWM on line zero, direction, enable
// - RGB duties independent, intensity on line three
// - Test mode ramp, sine, sync and cycle sync
`timescale 1ns/1ps
module pattern_gen #(
  parameter int ARB_DEPTH = 64,
  parameter int IW = $clog2(ARB_DEPTH)
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PATTERN_ENABLE,
  input wire pgen_pkg::mode_e MODE,
  input wire logic [31:0] SQ_PERIOD,
  input wire logic [6:0] SQ_DUTY,
  input wire logic SQ_INVERT,
  input wire logic [31:0] CNT_STEP,
  input wire logic CNT_DOWN,
  input wire logic [3:0] MAN_LEVEL,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  input wire logic [IW-1:0] SAMPLE_INDEX,
  input wire logic [3:0] SAMPLE_VALUE,
  input wire logic ARB_CLEAR,
  input wire logic ARB_LENGTH_WE,
  input wire logic [IW:0] ARB_LENGTH,
  input wire logic [31:0] BIT_TIME,
  input wire logic BURST_ENABLE,
  input wire logic [31:0] IDLE_STEPS,
  input wire logic [15:0] NCYCLE,
  input wire logic SINGLE_SHOT_MODE,
  input wire logic SINGLE_SHOT_TRIGGER,
  input wire logic [1:0] BUS_RATE_SEL,
  input wire logic UART_INVERT,
  input wire logic [31:0] PWM_PERIOD,
  input wire logic [6:0] PWM_DUTY,
  input wire logic MOTOR_DIR,
  input wire logic MOTOR_ENABLE,
  input wire logic [6:0] LED_RED,
  input wire logic [6:0] LED_GREEN,
  input wire logic [6:0] LED_BLUE,
  input wire logic [6:0] LED_INTENS,
  output logic [IW:0] ARB_LENGTH_NOW,
  output logic [3:0] SEL_VALUE,
  output logic SEQ_BUSY,
  output logic PATTERN_LINE_ZERO,
  output logic PATTERN_LINE_ONE,
  output logic PATTERN_LINE_TWO,
  output logic PATTERN_LINE_THREE,
  output logic LINE_DRIVE_EN
);
  import pgen_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  // Zero period is treated as one cycle
  function automatic logic [31:0] min1(input logic [31:0] v);
    min1 = (v == 32'h0) ? 32'h1 : v;
  endfunction

  // High-phase length of a period for a percentage
  function automatic logic [31:0] duty_hi(input logic [31:0] per, input logic [6:0] pct);
    logic [38:0] p;
    p = 39'(per) * 39'(pct);
    duty_hi = 32'(p / 39'(PCT_FULL));
  endfunction

  function automatic logic [6:0] clamp_pct(input logic [6:0] pct);
    clamp_pct = (pct < DUTY_MIN) ? DUTY_MIN : ((pct > DUTY_MAX) ? DUTY_MAX : pct);
  endfunction

  // Idle steps of 10 ns to clock cycles, rounded up
  function automatic logic [31:0] steps_to_cyc(input logic [31:0] s);
    logic [31:0] c;
    logic [35:0] ns;
    c = (s < IDLE_MIN_STEPS) ? IDLE_MIN_STEPS : ((s > IDLE_MAX_STEPS) ? IDLE_MAX_STEPS : s);
    ns = 36'(c) * 36'(IDLE_STEP_NS);
    steps_to_cyc = 32'((ns + 36'(CLK_PERIOD_NS - 1)) / 36'(CLK_PERIOD_NS));
  endfunction

  function automatic logic [31:0] half_of(input int rate);
    half_of = 32'(CLK_HZ / (2 * rate));
  endfunction

  // Half-bit length for each bus and rate choice
  function automatic logic [31:0] bus_half(input mode_e m, input logic [1:0] sel);
    bus_half = half_of(UART_R0);
    unique case (m)
      MODE_UART: bus_half = half_of(sel == 2'b00 ? UART_R0 : (sel == 2'b01 ? UART_R1 : UART_R2));
      MODE_SPI: bus_half = half_of(sel == 2'b00 ? SPI_R0 : (sel == 2'b01 ? SPI_R1 : SPI_R2));
      MODE_I2C: bus_half = half_of(sel == 2'b00 ? I2C_R0 : (sel == 2'b01 ? I2C_R1
                                   : (sel == 2'b10 ? I2C_R2 : I2C_R3)));
      MODE_CAN: bus_half = half_of(sel == 2'b00 ? CAN_R0 : (sel == 2'b01 ? CAN_R1 : CAN_R2));
      MODE_LIN: bus_half = half_of(sel == 2'b00 ? LIN_R0 : (sel == 2'b01 ? LIN_R1 : LIN_R2));
      default: bus_half = half_of(UART_R0);
    endcase
  endfunction

  // Coarse sine in percent over sixteen steps, quarter wave mirrored
  function automatic logic [6:0] sine_pct(input logic [3:0] ph);
    logic [2:0] m;
    logic [6:0] q;
    m = ph[2] ? 3'(3'h4 - {1'b0, ph[1:0]}) : {1'b0, ph[1:0]};
    q = 7'h32;
    unique case (m)
      3'h0: q = 7'h00;
      3'h1: q = 7'h13;
      3'h2: q = 7'h23;
      3'h3: q = 7'h2E;
      default: q = 7'h32;
    endcase
    sine_pct = ph[3] ? 7'h32 - q : 7'h32 + q;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [3:0] mem_reg [ARB_DEPTH];
  logic [IW:0] len_reg;
  logic [3:0] sel_reg;
  logic [IW-1:0] bf_idx_reg [2];
  logic [3:0] bf_val_reg [2];
  logic bf_wr_reg;
  logic bf_rd_reg;
  logic [1:0] bf_cnt_reg;
  seq_e seq_reg;
  logic [31:0] bit_cnt_reg;
  logic [31:0] idle_cnt_reg;
  // Step index also holds the sixteen test steps with a shallow memory
  localparam int SW = (IW >= $bits(MOD_LAST_STEP)) ? IW + 1 : $bits(MOD_LAST_STEP) + 1;
  logic [SW-1:0] idx_reg;
  logic [15:0] rep_reg;
  logic [31:0] pwm_cnt_reg;
  logic [31:0] cstep_reg;
  logic [3:0] count_reg;
  logic [31:0] ser_div_reg;
  logic ser_half_reg;
  logic [3:0] ser_bit_reg;
  logic [7:0] ser_byte_reg;
  logic [15:0] lfsr_reg;
  logic ser_prev_reg;
  logic [3:0] line_reg;
  logic drive_reg;

  // ****************************************
  // Sample write buffer
  // ****************************************
  logic bf_push;
  logic bf_pop;
  logic drain_ready;
  logic seq_step;
  logic seq_mode;
  logic arb_mode;
  assign SAMPLE_READY = (bf_cnt_reg != 2'b10) && !ARB_CLEAR;
  assign bf_push = SAMPLE_VALID && SAMPLE_READY;
  // Memory writes stall in the cycle the sequencer advances in arbitrary mode
  assign drain_ready = !(seq_reg == SEQ_RUN && seq_step && arb_mode);
  assign bf_pop = (bf_cnt_reg != 2'b00) && drain_ready && !ARB_CLEAR;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bf_wr_reg <= 1'b0;
      bf_rd_reg <= 1'b0;
      bf_cnt_reg <= 2'b00;
      bf_idx_reg[0] <= '0;
      bf_idx_reg[1] <= '0;
      bf_val_reg[0] <= 4'h0;
      bf_val_reg[1] <= 4'h0;
    end else if (ARB_CLEAR) begin
      bf_wr_reg <= 1'b0;
      bf_rd_reg <= 1'b0;
      bf_cnt_reg <= 2'b00;
    end else begin
      if (bf_push) begin
        bf_idx_reg[bf_wr_reg] <= SAMPLE_INDEX;
        bf_val_reg[bf_wr_reg] <= SAMPLE_VALUE;
        bf_wr_reg <= !bf_wr_reg;
      end
      if (bf_pop) begin
        bf_rd_reg <= !bf_rd_reg;
      end
      bf_cnt_reg <= 2'(bf_cnt_reg + {1'b0, bf_push} - {1'b0, bf_pop});
    end
  end

  // ****************************************
  // Sample memory and length
  // ****************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < ARB_DEPTH; i++) begin
        mem_reg[i] <= 4'h0;
      end
      len_reg <= (IW + 1)'(1);
      sel_reg <= 4'h0;
    end else if (ARB_CLEAR) begin
      for (int i = 0; i < ARB_DEPTH; i++) begin
        mem_reg[i] <= 4'h0;
      end
      len_reg <= (IW + 1)'(1);
      sel_reg <= 4'h0;
    end else begin
      if (bf_pop) begin
        mem_reg[bf_idx_reg[bf_rd_reg]] <= bf_val_reg[bf_rd_reg];
      end
      if (ARB_LENGTH_WE) begin
        len_reg <= (ARB_LENGTH == '0) ? (IW + 1)'(1)
                   : ((ARB_LENGTH > (IW + 1)'(ARB_DEPTH)) ? (IW + 1)'(ARB_DEPTH) : ARB_LENGTH);
      end
      sel_reg <= mem_reg[SAMPLE_INDEX];
    end
  end
  assign ARB_LENGTH_NOW = len_reg;
  assign SEL_VALUE = sel_reg;

  // ****************************************
  // Shared PWM carrier
  // ****************************************
  logic [31:0] pwm_per;
  logic pwm_wrap;
  assign pwm_per = min1(MODE == MODE_SQUARE ? SQ_PERIOD : PWM_PERIOD);
  assign pwm_wrap = (pwm_cnt_reg >= pwm_per - 32'h1);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pwm_cnt_reg <= 32'h0;
    end else if (!PATTERN_ENABLE || pwm_wrap) begin
      pwm_cnt_reg <= 32'h0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 32'h1;
    end
  end

  // ****************************************
  // Arbitrary and test-signal sequencer
  // ****************************************
  logic [SW-1:0] seq_len;
  logic last_idx;
  logic last_rep;
  logic bit_done;
  logic idle_done;
  logic seq_start;
  assign arb_mode = (MODE == MODE_ARB);
  assign seq_mode = PATTERN_ENABLE && (arb_mode || MODE == MODE_TEST);
  assign seq_len = arb_mode ? SW'(len_reg) : SW'(MOD_LAST_STEP) + SW'(1);
  assign bit_done = (bit_cnt_reg >= min1(BIT_TIME) - 32'h1);
  assign seq_step = arb_mode ? bit_done : pwm_wrap;
  assign last_idx = (idx_reg == seq_len - SW'(1));
  assign last_rep = (32'(rep_reg) + 32'h1 >= min1(32'(NCYCLE)));
  assign idle_done = (idle_cnt_reg >= steps_to_cyc(IDLE_STEPS) - 32'h1);
  assign seq_start = SINGLE_SHOT_MODE ? SINGLE_SHOT_TRIGGER : 1'b1;
  assign SEQ_BUSY = (seq_reg != SEQ_WAIT);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      seq_reg <= SEQ_WAIT;
      bit_cnt_reg <= 32'h0;
      idle_cnt_reg <= 32'h0;
      idx_reg <= '0;
      rep_reg <= 16'h0;
    end else if (!seq_mode || ARB_CLEAR) begin
      seq_reg <= SEQ_WAIT;
      bit_cnt_reg <= 32'h0;
      idle_cnt_reg <= 32'h0;
      idx_reg <= '0;
      rep_reg <= 16'h0;
    end else begin
      unique case (seq_reg)
        SEQ_WAIT: begin
          if (seq_start) begin
            seq_reg <= SEQ_RUN;
          end
          bit_cnt_reg <= 32'h0;
          idx_reg <= '0;
          rep_reg <= 16'h0;
        end
        SEQ_RUN: begin
          bit_cnt_reg <= bit_done ? 32'h0 : bit_cnt_reg + 32'h1;
          if (seq_step) begin
            if (last_idx) begin
              idx_reg <= '0;
              if (last_rep) begin
                rep_reg <= 16'h0;
                idle_cnt_reg <= 32'h0;
                if (BURST_ENABLE) begin
                  seq_reg <= SEQ_IDLE;
                end else if (SINGLE_SHOT_MODE) begin
                  seq_reg <= SEQ_WAIT;
                end
              end else begin
                rep_reg <= rep_reg + 16'h1;
              end
            end else begin
              idx_reg <= idx_reg + SW'(1);
            end
          end
        end
        SEQ_IDLE: begin
          idle_cnt_reg <= idle_cnt_reg + 32'h1;
          bit_cnt_reg <= 32'h0;
          if (idle_done) begin
            seq_reg <= SINGLE_SHOT_MODE ? SEQ_WAIT : SEQ_RUN;
          end
        end
        default: seq_reg <= SEQ_WAIT;
      endcase
    end
  end

  // ****************************************
  // Counter mode
  // ****************************************
  logic cnt_tick;
  assign cnt_tick = (cstep_reg >= min1(CNT_STEP) - 32'h1);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cstep_reg <= 32'h0;
      count_reg <= 4'h0;
    end else if (!PATTERN_ENABLE || MODE != MODE_COUNTER) begin
      cstep_reg <= 32'h0;
      count_reg <= 4'h0;
    end else begin
      cstep_reg <= cnt_tick ? 32'h0 : cstep_reg + 32'h1;
      if (cnt_tick) begin
        count_reg <= CNT_DOWN ? count_reg - 4'h1 : count_reg + 4'h1;
      end
    end
  end

  // ****************************************
  // Serial bus frame engine
  // ****************************************
  logic ser_mode;
  logic ser_tick;
  logic ser_bit_end;
  logic in_data;
  logic tx_bit;
  assign ser_mode = PATTERN_ENABLE && (MODE == MODE_UART || MODE == MODE_SPI || MODE == MODE_I2C
                                       || MODE == MODE_CAN || MODE == MODE_LIN);
  assign ser_tick = (ser_div_reg >= min1(bus_half(MODE, BUS_RATE_SEL)) - 32'h1);
  assign ser_bit_end = ser_tick && ser_half_reg;
  assign in_data = (ser_bit_reg != 4'h0) && (ser_bit_reg < FRAME_STOP_BIT);
  // Start low, eight data bits LSB first, stop and gap high
  assign tx_bit = (ser_bit_reg == 4'h0) ? 1'b0 : (in_data ? ser_byte_reg[3'(ser_bit_reg - 4'h1)] : 1'b1);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ser_div_reg <= 32'h0;
      ser_half_reg <= 1'b0;
      ser_bit_reg <= 4'h0;
      ser_byte_reg <= 8'h00;
      lfsr_reg <= LFSR_SEED;
      ser_prev_reg <= 1'b1;
    end else if (!ser_mode) begin
      ser_div_reg <= 32'h0;
      ser_half_reg <= 1'b0;
      ser_bit_reg <= 4'h0;
      ser_prev_reg <= 1'b1;
    end else begin
      ser_div_reg <= ser_tick ? 32'h0 : ser_div_reg + 32'h1;
      if (ser_tick) begin
        ser_half_reg <= !ser_half_reg;
      end
      if (ser_bit_end) begin
        ser_prev_reg <= tx_bit;
        if (ser_bit_reg == FRAME_LAST_BIT) begin
          ser_bit_reg <= 4'h0;
          ser_byte_reg <= lfsr_reg[7:0];
          lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        end else begin
          ser_bit_reg <= ser_bit_reg + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // Output selection
  // ****************************************
  logic sq_out;
  logic motor_pwm;
  logic [3:0] led_out;
  logic [3:0] test_out;
  logic [3:0] arb_out;
  logic [3:0] bus_out;
  logic [3:0] line_next;
  logic seq_run;
  assign seq_run = (seq_reg == SEQ_RUN);
  assign sq_out = (pwm_cnt_reg < duty_hi(pwm_per, clamp_pct(SQ_DUTY))) ^ SQ_INVERT;
  assign motor_pwm = (pwm_cnt_reg < duty_hi(pwm_per, clamp_pct(PWM_DUTY)));
  // Red, green, blue on lines zero to two, intensity on three
  assign led_out = {pwm_cnt_reg < duty_hi(pwm_per, LED_INTENS),
                    pwm_cnt_reg < duty_hi(pwm_per, LED_BLUE),
                    pwm_cnt_reg < duty_hi(pwm_per, LED_GREEN),
                    pwm_cnt_reg < duty_hi(pwm_per, LED_RED)};
  // Ramp, sine, sync at pattern start, sync per carrier cycle
  assign test_out = seq_run ? {pwm_cnt_reg == 32'h0,
                               idx_reg == '0,
                               pwm_cnt_reg < duty_hi(pwm_per, sine_pct(4'(idx_reg))),
                               pwm_cnt_reg < duty_hi(pwm_per, 7'(4'(idx_reg) * RAMP_STEP_PCT))}
                            : 4'h0;
  assign arb_out = seq_run ? mem_reg[IW'(idx_reg)] : 4'h0;

  always_comb begin
    bus_out = 4'h0;
    unique case (MODE)
      MODE_UART: bus_out = {2'b00, ser_prev_reg ^ UART_INVERT, tx_bit ^ UART_INVERT};
      MODE_SPI: bus_out = {!in_data, ser_prev_reg, tx_bit, in_data && ser_half_reg};
      MODE_I2C: bus_out = {2'b00, tx_bit, in_data ? ser_half_reg : 1'b1};
      MODE_CAN: bus_out = {2'b00, tx_bit, !tx_bit};
      MODE_LIN: bus_out = {2'b00, !tx_bit, tx_bit};
      default: bus_out = 4'h0;
    endcase
  end

  always_comb begin
    line_next = 4'h0;
    unique case (MODE)
      MODE_SQUARE: line_next = {3'b000, sq_out};
      MODE_COUNTER: line_next = count_reg;
      MODE_ARB: line_next = arb_out;
      MODE_MANUAL: line_next = MAN_LEVEL;
      MODE_PWM: line_next = {1'b0, MOTOR_ENABLE, MOTOR_DIR, motor_pwm};
      MODE_LED: line_next = led_out;
      MODE_TEST: line_next = test_out;
      default: line_next = bus_out;
    endcase
    if (!PATTERN_ENABLE) begin
      line_next = 4'h0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      line_reg <= 4'h0;
      drive_reg <= 1'b0;
    end else begin
      line_reg <= line_next;
      drive_reg <= PATTERN_ENABLE;
    end
  end

  assign PATTERN_LINE_ZERO = line_reg[0];
  assign PATTERN_LINE_ONE = line_reg[1];
  assign PATTERN_LINE_TWO = line_reg[2];
  assign PATTERN_LINE_THREE = line_reg[3];
  assign LINE_DRIVE_EN = drive_reg;
endmodule

// ===== pattern_gen_assertions.sv
// Port checker for the four-line pattern generator
`timescale 1ns/1ps
module pattern_gen_assertions #(
  parameter int IW = 2
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PATTERN_ENABLE,
  input wire pgen_pkg::mode_e MODE,
  input wire logic [31:0] CNT_STEP,
  input wire logic CNT_DOWN,
  input wire logic [3:0] MAN_LEVEL,
  input wire logic SAMPLE_READY,
  input wire logic ARB_CLEAR,
  input wire logic SINGLE_SHOT_MODE,
  input wire logic SINGLE_SHOT_TRIGGER,
  input wire logic [IW:0] ARB_LENGTH_NOW,
  input wire logic SEQ_BUSY,
  input wire logic PATTERN_LINE_ZERO,
  input wire logic PATTERN_LINE_ONE,
  input wire logic PATTERN_LINE_TWO,
  input wire logic PATTERN_LINE_THREE,
  input wire logic LINE_DRIVE_EN
);
  import pgen_pkg::*;
  logic [3:0] nib;
  logic cnt_run;
  // ****************************************
  // Helpers
  // ****************************************
  assign nib = {PATTERN_LINE_THREE, PATTERN_LINE_TWO, PATTERN_LINE_ONE, PATTERN_LINE_ZERO};
  assign cnt_run = PATTERN_ENABLE && MODE == MODE_COUNTER && CNT_STEP == 32'h1;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ****************************************
  // Properties
  // ****************************************
  a_off_quiet: assert property (!PATTERN_ENABLE |=> nib == 4'h0 && !LINE_DRIVE_EN)
    else $error("lines driven while disabled");
  a_drive_on: assert property (PATTERN_ENABLE |=> LINE_DRIVE_EN)
    else $error("drive enable missing");
  a_square_only: assert property (PATTERN_ENABLE && MODE == MODE_SQUARE |=> nib[3:1] == 3'h0)
    else $error("square wave off line zero");
  a_manual_level: assert property (PATTERN_ENABLE && MODE == MODE_MANUAL |=> nib == $past(MAN_LEVEL))
    else $error("manual level wrong");
  a_clear_length: assert property (ARB_CLEAR |=> ARB_LENGTH_NOW == (IW+1)'(1))
    else $error("length not one after clear");
  a_clear_refuse: assert property (ARB_CLEAR |-> !SAMPLE_READY)
    else $error("sample taken during clear");
  a_bus_idle: assert property (PATTERN_ENABLE && MODE inside {MODE_UART, MODE_I2C, MODE_CAN, MODE_LIN}
    |=> nib[3:2] == 2'h0) else $error("unused bus line active");
  a_count_step: assert property ((cnt_run && $stable(CNT_DOWN))[*3]
    |-> nib == (CNT_DOWN ? $past(nib) - 4'h1 : $past(nib) + 4'h1)) else $error("count step wrong");
  a_shot_wait: assert property (PATTERN_ENABLE && MODE == MODE_ARB && SINGLE_SHOT_MODE && !SEQ_BUSY
    && !SINGLE_SHOT_TRIGGER |=> !SEQ_BUSY) else $error("run without trigger");
endmodule

bind pattern_gen pattern_gen_assertions #(.IW(IW)) u_chk (.*);

// ===== pattern_gen_tb.sv
// Self-checking bench for the four-line pattern generator
`timescale 1ns/1ps
module pattern_gen_tb;
  import pgen_pkg::*;
  logic CLK = 1'b0, NRST = 1'b0, PATTERN_ENABLE = 1'b0, SQ_INVERT = 1'b0, CNT_DOWN = 1'b0;
  logic SAMPLE_VALID = 1'b0, ARB_CLEAR = 1'b0, ARB_LENGTH_WE = 1'b0, BURST_ENABLE = 1'b0;
  logic SINGLE_SHOT_MODE = 1'b0, SINGLE_SHOT_TRIGGER = 1'b0, UART_INVERT = 1'b0;
  logic MOTOR_DIR = 1'b0, MOTOR_ENABLE = 1'b0, mon_clr = 1'b0;
  mode_e MODE = MODE_MANUAL;
  logic [31:0] SQ_PERIOD = 32'hA, CNT_STEP = 32'h1, BIT_TIME = 32'h2, IDLE_STEPS = 32'h5, PWM_PERIOD = 32'hA;
  logic [6:0] SQ_DUTY = 7'h1E, PWM_DUTY = 7'h28, LED_RED = 7'h14, LED_GREEN = 7'h32;
  logic [6:0] LED_BLUE = 7'h50, LED_INTENS = 7'h1E;
  logic [3:0] MAN_LEVEL = 4'hF, SAMPLE_VALUE = 4'h0;
  logic [1:0] SAMPLE_INDEX = 2'h0, BUS_RATE_SEL = 2'h3;
  logic [2:0] ARB_LENGTH = 3'h1;
  logic [15:0] NCYCLE = 16'h1;
  logic SAMPLE_READY, SEQ_BUSY, LINE_DRIVE_EN;
  logic PATTERN_LINE_ZERO, PATTERN_LINE_ONE, PATTERN_LINE_TWO, PATTERN_LINE_THREE;
  logic [2:0] ARB_LENGTH_NOW;
  logic [3:0] SEL_VALUE, nib;
  logic [15:0] highs [4];
  logic [15:0] rises;
  int n_errors = 0;
  int checked = 0;
  assign nib = {PATTERN_LINE_THREE, PATTERN_LINE_TWO, PATTERN_LINE_ONE, PATTERN_LINE_ZERO};
  // Clock and units under test
  always #12.5 CLK = ~CLK;
  pattern_gen #(.ARB_DEPTH(4)) uut (.*);
  line_monitor u_mon (.clk(CLK), .clr(mon_clr), .lines(nib), .highs(highs), .rises(rises));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic measure(input int n);
    mon_clr <= 1'b1;
    @(posedge CLK);
    mon_clr <= 1'b0;
    repeat (n + 1) @(posedge CLK);
  endtask
  task automatic wr(input logic [1:0] i, input logic [3:0] v);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_INDEX <= i;
    SAMPLE_VALUE <= v;
    do @(posedge CLK); while (SAMPLE_READY !== 1'b1);
  endtask
  task automatic sq(input logic [31:0] p, input logic [6:0] d, input logic inv, input int e);
    SQ_PERIOD <= p;
    SQ_DUTY <= d;
    SQ_INVERT <= inv;
    repeat (2 * p) @(posedge CLK);
    measure(100);
    check("square high", highs[0], e);
    check("square others", highs[1] | highs[2] | highs[3], 0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_manual;
    repeat (3) @(posedge CLK);
    check("disabled lines", {LINE_DRIVE_EN, nib}, 0);
    PATTERN_ENABLE <= 1'b1;
    for (int v = 0; v < 16; v += 5) begin
      MAN_LEVEL <= 4'(v);
      repeat (3) @(posedge CLK);
      check("manual", nib, v);
    end
  endtask
  task automatic t_counter;
    MODE <= MODE_COUNTER;
    repeat (10) @(posedge CLK);
    CNT_DOWN <= 1'b1;
    repeat (10) @(posedge CLK);
    CNT_DOWN <= 1'b0;
    CNT_STEP <= 32'h2;
    repeat (8) @(posedge CLK);
    measure(64);
    for (int i = 0; i < 4; i++) check("counter high", highs[i], 32);
    check("counter rises", rises, 16);
  endtask
  task automatic t_square;
    MODE <= MODE_SQUARE;
    sq(32'hA, 7'h1E, 1'b0, 30);
    sq(32'hA, 7'h1E, 1'b1, 70);
    sq(32'h64, 7'h01, 1'b0, 1);
    sq(32'h64, 7'h63, 1'b0, 99);
  endtask
  task automatic t_pwm;
    MODE <= MODE_PWM;
    MOTOR_DIR <= 1'b1;
    MOTOR_ENABLE <= 1'b1;
    repeat (20) @(posedge CLK);
    measure(100);
    check("motor pwm", highs[0], 40);
    check("motor levels", highs[1] + highs[2] + highs[3], 200);
    MODE <= MODE_LED;
    repeat (20) @(posedge CLK);
    measure(100);
    for (int i = 0; i < 4; i++) check("led pwm", highs[i], 20 + 30 * i - (i == 3 ? 80 : 0));
  endtask
  task automatic t_bus;
    for (int m = 4; m < 8; m++) begin
      MODE <= mode_e'(m);
      UART_INVERT <= m[0];
      measure(1000);
      check("bus activity", 16'(rises != 0), 1);
    end
    MODE <= MODE_LIN;
    repeat (200) @(posedge CLK);
  endtask
  task automatic t_arb;
    int k;
    wr(2'h0, 4'hA);
    wr(2'h1, 4'h5);
    SAMPLE_VALID <= 1'b0;
    ARB_LENGTH <= 3'h2;
    ARB_LENGTH_WE <= 1'b1;
    @(posedge CLK);
    ARB_LENGTH_WE <= 1'b0;
    MODE <= MODE_ARB;
    repeat (2) @(posedge CLK);
    check("length", ARB_LENGTH_NOW, 2);
    for (k = 0; k < 40 && nib !== 4'hA; k++) @(posedge CLK);
    for (int i = 1; i < 5; i++) begin
      @(posedge CLK);
      check("arb sample", nib, (i == 2 || i == 3) ? 4'h5 : 4'hA);
    end
    SAMPLE_INDEX <= 2'h1;
    repeat (4) @(posedge CLK);
    check("sample readback", SEL_VALUE, 4'h5);
  endtask
  task automatic t_clear;
    ARB_CLEAR <= 1'b1;
    SAMPLE_VALID <= 1'b1;
    SAMPLE_VALUE <= 4'hF;
    @(posedge CLK);
    check("ready in clear", SAMPLE_READY, 0);
    ARB_CLEAR <= 1'b0;
    SAMPLE_VALID <= 1'b0;
    repeat (4) @(posedge CLK);
    check("cleared length", ARB_LENGTH_NOW, 1);
    check("cleared value", SEL_VALUE, 0);
  endtask
  task automatic t_shot(input logic [31:0] idle, input int exp);
    int busy = 0;
    SINGLE_SHOT_MODE <= 1'b1;
    BURST_ENABLE <= 1'b1;
    NCYCLE <= 16'h2;
    IDLE_STEPS <= idle;
    repeat (40) @(posedge CLK);
    repeat (10) @(posedge CLK) busy += int'(SEQ_BUSY === 1'b1);
    check("busy untriggered", busy, 0);
    SINGLE_SHOT_TRIGGER <= 1'b1;
    @(posedge CLK);
    SINGLE_SHOT_TRIGGER <= 1'b0;
    repeat (40) @(posedge CLK) busy += int'(SEQ_BUSY === 1'b1);
    check("burst span", busy, exp);
  endtask
  task automatic t_test;
    SINGLE_SHOT_MODE <= 1'b0;
    BURST_ENABLE <= 1'b0;
    MODE <= MODE_TEST;
    repeat (20) @(posedge CLK);
    measure(160);
    check("test cycle sync", highs[3], 16);
    check("test pattern sync", highs[2], 10);
    check("test modulation", 16'(highs[0] != 0 && highs[1] != 0), 1);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    t_manual();
    t_counter();
    t_square();
    t_pwm();
    t_bus();
    t_arb();
    t_clear();
    t_shot(32'h5, 6);
    t_shot(32'h2, 5);
    t_test();
    print_verdict();
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge CLK);
    n_errors++;
    print_verdict();
  end
endmodule

// ===== pgen_pkg.sv
// Constants and types shared by the pattern generator
package pgen_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int IDLE_STEP_NS = 10;
  localparam logic [31:0] IDLE_MIN_STEPS = 32'h0000_0002;
  localparam logic [31:0] IDLE_MAX_STEPS = 32'hFA56_EA00;

  // ****************************************
  // Duty cycle limits in percent
  // ****************************************
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] DUTY_MIN = 7'h01;
  localparam logic [6:0] DUTY_MAX = 7'h63;
  localparam logic [6:0] RAMP_STEP_PCT = 7'h06;

  // ****************************************
  // Serial bus rates in bit/s
  // ****************************************
  localparam int UART_R0 = 9600;
  localparam int UART_R1 = 115200;
  localparam int UART_R2 = 1000000;
  localparam int SPI_R0 = 100000;
  localparam int SPI_R1 = 250000;
  localparam int SPI_R2 = 1000000;
  localparam int I2C_R0 = 100000;
  localparam int I2C_R1 = 400000;
  localparam int I2C_R2 = 1000000;
  localparam int I2C_R3 = 3400000;
  localparam int CAN_R0 = 50000;
  localparam int CAN_R1 = 100000;
  localparam int CAN_R2 = 1000000;
  localparam int LIN_R0 = 9600;
  localparam int LIN_R1 = 10417;
  localparam int LIN_R2 = 19200;

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam logic [3:0] FRAME_STOP_BIT = 4'h9;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hB;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // Last test signal modulation step index per pattern
  localparam logic [3:0] MOD_LAST_STEP = 4'hF;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [3:0] {
    MODE_SQUARE = 4'b0000,
    MODE_COUNTER = 4'b0001,
    MODE_ARB = 4'b0010,
    MODE_MANUAL = 4'b0011,
    MODE_UART = 4'b0100,
    MODE_SPI = 4'b0101,
    MODE_I2C = 4'b0110,
    MODE_CAN = 4'b0111,
    MODE_LIN = 4'b1000,
    MODE_PWM = 4'b1001,
    MODE_LED = 4'b1010,
    MODE_TEST = 4'b1011
  } mode_e;

  typedef enum logic [1:0] {
    SEQ_WAIT = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_IDLE = 2'b10
  } seq_e;

endpackage
